// ---- rtl/cgf_regs.vh ----
`ifndef CGF_REGS_VH
`define CGF_REGS_VH
// ****************************************************************
// register map (byte addresses, axi4-lite, 32-bit words)
// ****************************************************************
`define CGF_ADDR_W        5
`define CGF_A_GROUP_CFG   5'h00
`define CGF_A_ACTIVE      5'h04
`define CGF_A_STATUS      5'h08
`define CGF_A_CHAN_CFG    5'h0c
`define CGF_A_CHAN_SEL    5'h10
// group configuration fields
`define CGF_F_MAP         1:0
`define CGF_F_ABORT       2
`define CGF_F_SUBDIS      3
`define CGF_F_BSD_EN      4
`define CGF_F_MSK_AC      5
`define CGF_F_MSK_LF      6
`define CGF_F_MSK_RCV     7
`define CGF_F_MODE        10:8
`define CGF_F_NSLOTS      23:16
`define CGF_GROUP_CFG_RST 32'h0000_0000
// channel configuration fields
`define CGF_F_BASE        6:0
`define CGF_F_HLEN        13:8
`define CGF_F_CHAN        20:16
`define CGF_F_TOL_TX      29:24
// ****************************************************************
// frame modes and slot counts
// ****************************************************************
`define CGF_MODE_T1       3'h0
`define CGF_MODE_E1       3'h1
`define CGF_MODE_2E1      3'h2
`define CGF_MODE_4E1      3'h3
`define CGF_MODE_NX64     3'h4
`define CGF_SLOTS_T1      8'h18
`define CGF_SLOTS_E1      8'h20
`define CGF_SLOTS_2E1     8'h40
`define CGF_SLOTS_4E1     8'h80
`define CGF_SYNC_EVENTS   2'h2
// ****************************************************************
// buffer memory areas (dwords) and descriptor codes
// ****************************************************************
`define CGF_FIXED_DW      8'h40
`define CGF_SUBMAP_DW     8'h40
`define CGF_TSMAP_DW      8'h20
`define CGF_CODE_AC       2'h1
`define CGF_CODE_LF       2'h2
`define CGF_CODE_RCV      2'h3
`define CGF_RESP_OKAY     2'h0
`define CGF_RESP_SLVERR   2'h2
`endif

// ---- rtl/cgf_sync2.v ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two-flop synchroniser for inputs from outside clk_in's domain
// ****************************************************************
module cgf_sync2 #(
  parameter W = 1
) (
  input  wire         clk_in,
  input  wire         rst_in,
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);
  reg [W-1:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= {W{1'b0}};
      q_out  <= {W{1'b0}};
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/cgf_chan_ram.v ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// per-channel fifo allocation table, one write and two read ports
// ****************************************************************
module cgf_chan_ram #(
  parameter AW = 5,
  parameter DW = 13
) (
  input  wire          clk_in,
  input  wire          we_in,
  input  wire [AW-1:0] waddr_in,
  input  wire [DW-1:0] wdata_in,
  input  wire [AW-1:0] raddr_a_in,
  input  wire [AW-1:0] raddr_b_in,
  output reg  [DW-1:0] rdata_a_out,
  output reg  [DW-1:0] rdata_b_out
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // read data registered; contents undefined until written
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_a_out <= mem[raddr_a_in];
    rdata_b_out <= mem[raddr_b_in];
  end
endmodule
`default_nettype wire

// ---- rtl/cgf_top.v ----
// Function
// - flag alignment change on any unexpected frame sync, even the first
// - hold alignment change one frame; end active messages during the map walk
// - alignment change: status descriptor with its code if enabled, then next descriptor
// - when alignment change drops, emit its interrupt unless masked
// - sync rising edge during alignment change emits its interrupt at once
// - no alignment change detection in the variable n x 64k mode
// - sample loss-of-framing input on every bit
// - on framing loss abort active channels if abort bit set, else keep receiving
// - framing-loss termination returns ownership, optional status, next descriptor
// - two frame events after framing loss, emit loss interrupt unless masked
// - framing back: resume at once, two frame events later recovered interrupt
// - up to eight ports, each with a 32-channel group
// - map 0 (reset) ties each port to its own group
// - map 1 ties ports 0 to 3 to group pairs
// - map 2 ties port 0 to groups 0-3, port 1 to 4-7, disables others
// - frames of 24, 32, 64, 128 slots or variable up to 128
// - each direction has 64 fixed, 64 subchannel map, 32 slot map dwords
// - each channel fifo alternates halves between serial side and memory side
// - subchannel disable 0 gives 64 data dwords, 1 gives 128
// - latency tolerance is half length plus one (tx) or two (rx) dwords
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cgf_regs.vh"
module cgf_top #(
  parameter NCH = 32
) (
  input  wire                   clk_in,
  input  wire                   rst_in,
  // axi4-lite slave
  input  wire [`CGF_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output reg                    s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output reg                    s_axi_wready,
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`CGF_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output reg                    s_axi_arready,
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // serial port pins from the line interface
  input  wire                   line_clk_in,
  input  wire                   rx_frame_sync_in,
  input  wire                   tx_frame_sync_in,
  input  wire                   rx_loss_of_framing_in,
  // message processor side
  input  wire [NCH-1:0]         chan_busy_in,
  input  wire                   fifo_req_in,
  input  wire [4:0]             fifo_chan_in,
  input  wire [5:0]             fifo_word_in,
  input  wire                   fifo_half_done_in,
  // outputs
  output reg                    frame_alignment_change_out,
  output reg                    rx_enable_out,
  output reg                    term_valid_out,
  output reg  [4:0]             term_chan_out,
  output reg  [1:0]             term_code_out,
  output reg                    term_owner_return_out,
  output reg                    term_status_write_out,
  output reg                    int_valid_out,
  output reg  [1:0]             int_code_out,
  output reg  [23:0]            group_port_out,
  output reg  [7:0]             port_enable_out,
  output reg  [6:0]             fifo_addr_out,
  output reg                    fifo_addr_valid_out,
  output reg                    fifo_range_err_out
);
  // ****************************************************************
  // functions
  // ****************************************************************
  // bits per frame for the configured mode
  function [10:0] frame_bits;
    input [2:0] mode;
    input [7:0] nslots;
    reg   [7:0] s;
    begin
      s = nslots;
      case (mode)
        `CGF_MODE_T1:  s = `CGF_SLOTS_T1;
        `CGF_MODE_E1:  s = `CGF_SLOTS_E1;
        `CGF_MODE_2E1: s = `CGF_SLOTS_2E1;
        `CGF_MODE_4E1: s = `CGF_SLOTS_4E1;
        default:       s = nslots;
      endcase
      frame_bits = {s, 3'b000};
    end
  endfunction

  // port serving a group under the mapping value
  function [2:0] port_of;
    input [1:0] map;
    input [2:0] grp;
    begin
      case (map)
        2'h1:    port_of = {1'b0, grp[2:1]};
        2'h2:    port_of = {2'b00, grp[2]};
        default: port_of = grp;
      endcase
    end
  endfunction

  // ****************************************************************
  // registers and bus slave
  // ****************************************************************
  reg  [31:0]  gcfg_q;
  reg  [NCH-1:0] active_q;
  reg  [4:0]   sel_q;
  reg          ram_we_q;
  reg  [12:0]  ram_wdata_q;
  reg  [4:0]   ram_waddr_q;
  reg          rd_pend_q;
  reg  [`CGF_ADDR_W-1:0] rd_addr_q;
  wire [12:0]  ram_a;
  wire [12:0]  ram_b;
  reg          ac_q;
  reg          lf_q;
  reg          have_sync_q;
  reg          walk_q;
  reg  [NCH-1:0] half_q;
  wire         wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;

  // writes take address and data together
  always @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CGF_RESP_OKAY;
      gcfg_q        <= `CGF_GROUP_CFG_RST;
      active_q      <= {NCH{1'b0}};
      sel_q         <= 5'h00;
      ram_we_q      <= 1'b0;
      ram_wdata_q   <= 13'h0000;
      ram_waddr_q   <= 5'h00;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      ram_we_q      <= 1'b0;
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `CGF_RESP_OKAY;
        case (s_axi_awaddr)
          `CGF_A_GROUP_CFG: gcfg_q <= s_axi_wdata;
          `CGF_A_ACTIVE:    active_q <= s_axi_wdata[NCH-1:0];
          `CGF_A_CHAN_SEL:  sel_q <= s_axi_wdata[4:0];
          `CGF_A_CHAN_CFG: begin
            ram_we_q    <= 1'b1;
            ram_waddr_q <= s_axi_wdata[`CGF_F_CHAN];
            ram_wdata_q <= {s_axi_wdata[`CGF_F_HLEN], s_axi_wdata[`CGF_F_BASE]};
            sel_q       <= s_axi_wdata[`CGF_F_CHAN];
          end
          `CGF_A_STATUS: s_axi_bresp <= `CGF_RESP_OKAY;
          default:       s_axi_bresp <= `CGF_RESP_SLVERR;
        endcase
      end
    end
  end

  // reads wait a cycle for the registered table lookup
  always @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CGF_RESP_OKAY;
      rd_pend_q     <= 1'b0;
      rd_addr_q     <= {`CGF_ADDR_W{1'b0}};
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~rd_pend_q & ~s_axi_rvalid;
      if (s_axi_arvalid & ~s_axi_arready & ~rd_pend_q & ~s_axi_rvalid) begin
        rd_pend_q <= 1'b1;
        rd_addr_q <= s_axi_araddr;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_pend_q & ~ram_we_q) begin
        rd_pend_q    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `CGF_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (rd_addr_q)
          `CGF_A_GROUP_CFG: s_axi_rdata <= gcfg_q;
          `CGF_A_ACTIVE:    s_axi_rdata <= active_q;
          `CGF_A_CHAN_SEL:  s_axi_rdata <= {27'h0000000, sel_q};
          `CGF_A_STATUS:    s_axi_rdata <= {28'h0000000, walk_q, have_sync_q, lf_q, ac_q};
          `CGF_A_CHAN_CFG: begin
            // tx tolerance half length + 1 dwords
            s_axi_rdata[`CGF_F_BASE]   <= ram_a[6:0];
            s_axi_rdata[`CGF_F_HLEN]   <= ram_a[12:7];
            s_axi_rdata[`CGF_F_CHAN]   <= sel_q;
            s_axi_rdata[`CGF_F_TOL_TX] <= ram_a[12:7] + 6'h01;
            s_axi_rdata[31:30]         <= {1'b0, half_q[sel_q]};
          end
          default: s_axi_rresp <= `CGF_RESP_SLVERR;
        endcase
      end
    end
  end

  // ****************************************************************
  // port to group mapping
  // ****************************************************************
  integer g;
  always @(posedge clk_in) begin
    if (rst_in) begin
      group_port_out  <= 24'hfac688;
      port_enable_out <= 8'hff;
    end else begin
      for (g = 0; g < 8; g = g + 1) begin
        group_port_out[g*3 +: 3] <= port_of(gcfg_q[`CGF_F_MAP], g[2:0]);
      end
      case (gcfg_q[`CGF_F_MAP])
        2'h1:    port_enable_out <= 8'h0f;
        2'h2:    port_enable_out <= 8'h03;
        default: port_enable_out <= 8'hff;
      endcase
    end
  end

  // ****************************************************************
  // line sampling: every line clock rise is one bit time
  // ****************************************************************
  wire [3:0] pins_s;
  reg  [3:0] pins_p_q;
  cgf_sync2 #(.W(4)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({rx_loss_of_framing_in, tx_frame_sync_in, rx_frame_sync_in, line_clk_in}),
    .q_out  (pins_s)
  );
  always @(posedge clk_in) begin
    if (rst_in) begin
      pins_p_q <= 4'h0;
    end else if (pins_s[0] & ~pins_p_q[0]) begin
      pins_p_q <= pins_s;
    end else begin
      pins_p_q[0] <= pins_s[0];
    end
  end
  wire bit_tick = pins_s[0] & ~pins_p_q[0];
  wire rs_rise  = bit_tick & pins_s[1] & ~pins_p_q[1];
  wire ts_rise  = bit_tick & pins_s[2] & ~pins_p_q[2];
  wire lf_in    = pins_s[3];

  // ****************************************************************
  // frame alignment, loss of framing and interrupt generation
  // ****************************************************************
  wire [10:0] flen = frame_bits(gcfg_q[`CGF_F_MODE], gcfg_q[`CGF_F_NSLOTS]);
  wire        nx64 = (gcfg_q[`CGF_F_MODE] == `CGF_MODE_NX64);
  reg  [10:0] bit_cnt_q;
  reg  [10:0] ac_cnt_q;
  reg  [1:0]  ev_cnt_q;
  reg         ev_run_q;
  reg  [2:0]  pend_q;
  reg  [4:0]  walk_idx_q;
  reg  [1:0]  walk_code_q;
  wire        last_bit  = (bit_cnt_q == flen - 11'h001);
  wire        unexp     = rs_rise & (~have_sync_q | ~last_bit);
  wire        frame_evt = bit_tick & (rs_rise | last_bit);
  wire        new_ac    = unexp & ~nx64;
  wire        ac_end    = bit_tick & ac_q & ~new_ac & (ac_cnt_q == flen - 11'h001);
  wire        lf_rise   = bit_tick & lf_in & ~lf_q;
  wire        lf_fall   = bit_tick & ~lf_in & lf_q;
  wire        ev_done   = ev_run_q & frame_evt & (ev_cnt_q == `CGF_SYNC_EVENTS - 2'h1);
  wire [2:0]  pend_set;
  assign pend_set[0] = (ac_end | (ac_q & ts_rise) | (ac_q & rs_rise)) & ~gcfg_q[`CGF_F_MSK_AC];
  assign pend_set[1] = ev_done & lf_q & ~gcfg_q[`CGF_F_MSK_LF];
  assign pend_set[2] = ev_done & ~lf_q & ~gcfg_q[`CGF_F_MSK_RCV];

  always @(posedge clk_in) begin
    if (rst_in) begin
      bit_cnt_q   <= 11'h000;
      ac_cnt_q    <= 11'h000;
      ac_q        <= 1'b0;
      have_sync_q <= 1'b0;
      lf_q        <= 1'b0;
      ev_cnt_q    <= 2'h0;
      ev_run_q    <= 1'b0;
    end else if (bit_tick) begin
      // flywheel keeps timing without external sync
      bit_cnt_q <= (rs_rise | last_bit) ? 11'h000 : bit_cnt_q + 11'h001;
      if (rs_rise) begin
        have_sync_q <= 1'b1;
      end
      if (new_ac) begin
        ac_q     <= 1'b1;
        ac_cnt_q <= 11'h000;
      end else if (ac_end) begin
        ac_q <= 1'b0;
      end else if (ac_q) begin
        ac_cnt_q <= ac_cnt_q + 11'h001;
      end
      lf_q <= lf_in;
      if (lf_rise | lf_fall) begin
        ev_run_q <= 1'b1;
        ev_cnt_q <= 2'h0;
      end else if (ev_done) begin
        ev_run_q <= 1'b0;
      end else if (ev_run_q & frame_evt) begin
        ev_cnt_q <= ev_cnt_q + 2'h1;
      end
    end
  end

  // pending codes drain one per cycle; a new event beats the drain
  always @(posedge clk_in) begin
    if (rst_in) begin
      pend_q        <= 3'h0;
      int_valid_out <= 1'b0;
      int_code_out  <= 2'h0;
    end else begin
      int_valid_out <= |pend_q;
      if (pend_q[0]) begin
        int_code_out <= `CGF_CODE_AC;
        pend_q       <= (pend_q & 3'b110) | pend_set;
      end else if (pend_q[1]) begin
        int_code_out <= `CGF_CODE_LF;
        pend_q       <= (pend_q & 3'b100) | pend_set;
      end else if (pend_q[2]) begin
        int_code_out <= `CGF_CODE_RCV;
        pend_q       <= pend_set;
      end else begin
        pend_q <= pend_set;
      end
    end
  end

  // ****************************************************************
  // channel map walk: terminates active mid-message receive channels
  // ****************************************************************
  wire abort_lf = lf_rise & gcfg_q[`CGF_F_ABORT];
  always @(posedge clk_in) begin
    if (rst_in) begin
      walk_q                <= 1'b0;
      walk_idx_q            <= 5'h00;
      walk_code_q           <= `CGF_CODE_AC;
      term_valid_out        <= 1'b0;
      term_chan_out         <= 5'h00;
      term_code_out         <= 2'h0;
      term_owner_return_out <= 1'b0;
      term_status_write_out <= 1'b0;
    end else begin
      term_valid_out        <= 1'b0;
      term_status_write_out <= 1'b0;
      term_owner_return_out <= 1'b0;
      if (new_ac | abort_lf) begin
        // a new event restarts the walk, far shorter than a frame
        walk_q      <= 1'b1;
        walk_idx_q  <= 5'h00;
        walk_code_q <= new_ac ? `CGF_CODE_AC : `CGF_CODE_LF;
      end else if (walk_q) begin
        walk_idx_q <= walk_idx_q + 5'h01;
        if (walk_idx_q == NCH - 1) begin
          walk_q <= 1'b0;
        end
        if (active_q[walk_idx_q] & chan_busy_in[walk_idx_q]) begin
          term_valid_out        <= 1'b1;
          term_chan_out         <= walk_idx_q;
          term_code_out         <= walk_code_q;
          term_status_write_out <= gcfg_q[`CGF_F_BSD_EN];
          term_owner_return_out <= 1'b1;
        end
      end
    end
  end

  // receive stops only while framing is lost with abort set
  always @(posedge clk_in) begin
    if (rst_in) begin
      frame_alignment_change_out <= 1'b0;
      rx_enable_out              <= 1'b1;
    end else begin
      frame_alignment_change_out <= ac_q;
      rx_enable_out              <= ~(lf_q & gcfg_q[`CGF_F_ABORT]);
    end
  end

  // ****************************************************************
  // fifo allocation: base, half length, ping-pong half
  // ****************************************************************
  reg        req_q;
  reg [5:0]  word_q;
  reg [4:0]  chan_q;
  wire [7:0] area = gcfg_q[`CGF_F_SUBDIS] ? (`CGF_FIXED_DW + `CGF_SUBMAP_DW) : `CGF_FIXED_DW;
  wire [7:0] half = {2'b00, ram_b[12:7]} + 8'h01;
  wire [7:0] offs = {1'b0, ram_b[6:0]} + (half_q[chan_q] ? half : 8'h00) + {2'b00, word_q};
  wire [7:0] rend = {1'b0, ram_b[6:0]} + {half[6:0], 1'b0};

  cgf_chan_ram #(.AW(5), .DW(13)) u_ram (
    .clk_in      (clk_in),
    .we_in       (ram_we_q),
    .waddr_in    (ram_waddr_q),
    .wdata_in    (ram_wdata_q),
    .raddr_a_in  (sel_q),
    .raddr_b_in  (fifo_chan_in),
    .rdata_a_out (ram_a),
    .rdata_b_out (ram_b)
  );

  always @(posedge clk_in) begin
    if (rst_in) begin
      req_q               <= 1'b0;
      word_q              <= 6'h00;
      chan_q              <= 5'h00;
      half_q              <= {NCH{1'b0}};
      fifo_addr_out       <= 7'h00;
      fifo_addr_valid_out <= 1'b0;
      fifo_range_err_out  <= 1'b0;
    end else begin
      req_q  <= fifo_req_in;
      word_q <= fifo_word_in;
      chan_q <= fifo_chan_in;
      if (fifo_half_done_in) begin
        half_q[fifo_chan_in] <= ~half_q[fifo_chan_in];
      end
      fifo_addr_valid_out <= req_q;
      if (req_q) begin
        fifo_addr_out      <= offs[6:0];
        fifo_range_err_out <= (rend > area);
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/cgf_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********
// line side: bit clock, frame syncs, framing loss
// ********
module cgf_line_model #(
  parameter int NBITS = 192
) (
  input  wire logic enable_in,
  input  wire logic slip_in,
  input  wire logic lf_in,
  output var  logic line_clk_out,
  output wire logic rx_frame_sync_out,
  output wire logic tx_frame_sync_out,
  output var  logic rx_loss_of_framing_out
);
  int cnt = 1;
  initial line_clk_out = 1'h0;
  initial rx_loss_of_framing_out = 1'h0;
  // clock idles low between runs
  always #62.5 line_clk_out = enable_in & ~line_clk_out;
  // change on falling edges; a slip restarts the frame, misplacing its sync
  always @(negedge line_clk_out) begin
    cnt <= (slip_in || cnt == NBITS - 1) ? 0 : cnt + 1;
    rx_loss_of_framing_out <= lf_in;
  end
  assign rx_frame_sync_out = enable_in && cnt == 0;
  assign tx_frame_sync_out = rx_frame_sync_out;
endmodule
`default_nettype wire

// ---- testbench/cgf_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********
// port checks
// ********
module cgf_top_monitor (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        frame_alignment_change_out,
  input wire logic        rx_enable_out,
  input wire logic        term_valid_out,
  input wire logic [1:0]  term_code_out,
  input wire logic        term_owner_return_out,
  input wire logic        int_valid_out,
  input wire logic [1:0]  int_code_out,
  input wire logic [23:0] group_port_out,
  input wire logic [7:0]  port_enable_out,
  input wire logic        fifo_req_in,
  input wire logic        fifo_addr_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  map_single_a: assert property (group_port_out == 24'hfac688 |-> port_enable_out == 8'hff)
    else $error("ports off in map 0");
  map_quad_a: assert property (group_port_out == 24'h249000 |-> port_enable_out[7:2] == 6'h00)
    else $error("upper ports on in map 2");
  ac_term_a: assert property (term_valid_out && term_code_out == 2'h1 |-> frame_alignment_change_out)
    else $error("alignment term unheld");
  lf_term_a: assert property (term_valid_out && term_code_out == 2'h2 |-> !rx_enable_out)
    else $error("loss term while receiving");
  owner_back_a: assert property (term_valid_out |-> term_owner_return_out)
    else $error("ownership kept");
  ac_int_a: assert property (int_valid_out && int_code_out == 2'h1 |-> frame_alignment_change_out
    || $past(frame_alignment_change_out) || $past(frame_alignment_change_out, 3))
    else $error("alignment irq unheld");
  fifo_lat_a: assert property (fifo_req_in |-> ##2 fifo_addr_valid_out)
    else $error("fifo address late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
    |=> s_axi_awready && s_axi_bvalid)
    else $error("write not answered");
endmodule
bind cgf_top cgf_top_monitor u_cgf_top_monitor (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cgf_regs.vh"
module testbench;
  logic        clk_in = 1'h0, rst_in = 1'h1, line_on = 1'h0, slip = 1'h0, lf = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, fifo_req_in = 1'h0, fifo_half_done_in = 1'h0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00, fifo_chan_in = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, chan_busy_in = 32'h0, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [5:0]  fifo_word_in = 6'h00;
  logic [1:0]  rs;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, line_clk_in;
  wire         rx_frame_sync_in, tx_frame_sync_in, rx_loss_of_framing_in, frame_alignment_change_out;
  wire         rx_enable_out, term_valid_out, term_owner_return_out, term_status_write_out, int_valid_out;
  wire         fifo_addr_valid_out, fifo_range_err_out;
  wire [1:0]   s_axi_bresp, s_axi_rresp, term_code_out, int_code_out;
  wire [31:0]  s_axi_rdata;
  wire [23:0]  group_port_out;
  wire [7:0]   port_enable_out;
  wire [6:0]   fifo_addr_out;
  wire [4:0]   term_chan_out;
  int          num_errors = 0, tests_run = 0, n, cnt [0:5] = '{default: 0};
  always #5 clk_in = ~clk_in;
  cgf_top u_cgf_top (.*);
  cgf_line_model u_cgf_line_model (.enable_in(line_on), .slip_in(slip), .lf_in(lf), .line_clk_out(line_clk_in),
    .rx_frame_sync_out(rx_frame_sync_in), .tx_frame_sync_out(tx_frame_sync_in),
    .rx_loss_of_framing_out(rx_loss_of_framing_in));
  // tallies: held ends, interrupt codes 1-3, busy-channel terminations 4-5
  always @(posedge clk_in) begin
    cnt[0] += $fell(frame_alignment_change_out);
    if (int_valid_out) cnt[int_code_out]++;
    if (term_valid_out && term_chan_out[0] == term_chan_out[4])
      cnt[term_code_out + 3] += term_code_out[0] ? term_status_write_out : term_owner_return_out;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("%0d errors, %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // a used-up bound fails the run
  task automatic guard(input int i, lim);
    if (i >= lim) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_in);
      i++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && i < 100);
    s_axi_bready <= 1'h0;
    guard(i, 100);
  endtask
  task automatic rdr(input logic [4:0] a);
    int i;
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_in);
      i++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && i < 100);
    s_axi_rready <= 1'h0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    guard(i, 100);
  endtask
  task automatic wait_cnt(input int k, m);
    int i;
    while (cnt[k] < m && i < 30000) begin
      @(posedge clk_in);
      i++;
    end
    guard(i, 30000);
  endtask
  // address stands two edges after the request
  task automatic fifo(input logic [4:0] c, input logic [5:0] w, input logic [6:0] a, input logic e, f);
    @(posedge clk_in);
    fifo_chan_in <= c;
    fifo_word_in <= w;
    fifo_req_in <= 1'h1;
    @(posedge clk_in);
    fifo_req_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    check("fifo_addr", fifo_addr_out, a);
    check("fifo_err", fifo_range_err_out, e);
    fifo_half_done_in <= f;
    @(posedge clk_in);
    fifo_half_done_in <= 1'h0;
  endtask
  // ********
  // main sequence
  // ********
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'h0;
    check("gport", group_port_out, 24'hfac688);
    rdr(`CGF_A_GROUP_CFG);
    check("cfg", rd, `CGF_GROUP_CFG_RST);
    rdr(5'h14);
    check("unmap", rs, `CGF_RESP_SLVERR);
    wr(`CGF_A_GROUP_CFG, 32'h1);
    rdr(`CGF_A_GROUP_CFG);
    check("map1", group_port_out, 24'h6d2240);
    wr(`CGF_A_GROUP_CFG, 32'h2);
    rdr(`CGF_A_GROUP_CFG);
    check("map2", group_port_out, 24'h249000);
    // abort and status writes on; regions set before activation
    wr(`CGF_A_GROUP_CFG, 32'h14);
    wr(`CGF_A_CHAN_CFG, 32'h0003_0108);
    rdr(`CGF_A_CHAN_CFG);
    check("tol", rd[29:24], 6'h02);
    fifo(5'h03, 6'h01, 7'h09, 1'h0, 1'h1);
    fifo(5'h03, 6'h01, 7'h0b, 1'h0, 1'h0);
    wr(`CGF_A_CHAN_CFG, 32'h0004_033c);
    fifo(5'h04, 6'h00, 7'h3c, 1'h1, 1'h0);
    wr(`CGF_A_GROUP_CFG, 32'h1c);
    fifo(5'h04, 6'h00, 7'h3c, 1'h0, 1'h0);
    wr(`CGF_A_ACTIVE, 32'hffff_ffff);
    chan_busy_in <= 32'h8000_0001;
    line_on <= 1'h1;
    wait_cnt(1, 1);
    check("ac_term", cnt[4], 2);
    // masked: a slip terminates silently
    wr(`CGF_A_GROUP_CFG, 32'h3c);
    n = cnt[1];
    slip <= 1'h1;
    repeat (13) @(posedge clk_in);
    slip <= 1'h0;
    wait_cnt(0, 2);
    check("ac_mask", cnt[1], n);
    // n x 64 ignores misplaced syncs; a frame is 2400 cycles
    wr(`CGF_A_GROUP_CFG, 32'h0018_043c);
    n = cnt[4];
    slip <= 1'h1;
    repeat (13) @(posedge clk_in);
    slip <= 1'h0;
    repeat (3000) @(posedge clk_in);
    check("nx64", cnt[4], n);
    wr(`CGF_A_GROUP_CFG, 32'h1c);
    lf <= 1'h1;
    repeat (300) @(posedge clk_in);
    check("rx_off", rx_enable_out, 1'h0);
    check("lf_early", cnt[2], 0);
    wait_cnt(2, 1);
    check("lf_term", cnt[5], 2);
    lf <= 1'h0;
    repeat (300) @(posedge clk_in);
    check("rx_on", rx_enable_out, 1'h1);
    check("rcv_early", cnt[3], 0);
    wait_cnt(3, 1);
    end_of_test();
  end
endmodule
`default_nettype wire
